// file: core/usb_ep_ctl.sv
// Endpoint status, toggle and handshake control for a full-speed USB function
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// - Bus reset zeroes control toggles and status
// - Endpoint 0 success sets control done flag
// - Control tx toggle forced one on setup
// - Tx toggle inverts only on host ack
// - Software may write both toggle bits
// - Control tx status uses four-state encoding
// - Control rx status uses same encoding
// - Endpoint 0 success sets both to nak
// - Setup stage clears control rx toggle
// - Rx toggle inverts on matching good data
// - Setup on enabled endpoint acked, nak both
// - Stall answer sets both fields stall
// - Reserved bits read zero, ignore writes
// - Bus reset clears endpoint bits 2:0
// - Good IN sets endpoint tx done
// - Endpoint tx status four-state encoding
// - Endpoint success overwrites tx status nak
// - Only address match lets endpoint take part
// - Good OUT on endpoint 2 sets rx done
// - Endpoint 2 rx status nak after success
`include "usb_ep_ctl_params.svh"
module usb_ep_ctl (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst,
	input  wire usb_ep_ctl_pkg::reg_req_t i_req,
	output logic [7:0]                    o_rdata,
	input  wire logic                     i_bus_reset,
	input  wire usb_ep_ctl_pkg::xact_t    i_xact,
	input  wire logic [1:0]               i_tok_pid,
	input  wire logic [2:0]               i_tok_ep,
	input  wire logic [6:0]               i_tok_addr,
	output usb_ep_ctl_pkg::handshake_t    o_handshake,
	output logic                          o_tx_pid,
	output logic                          o_rx_expect
);
	import usb_ep_ctl_pkg::*;

	localparam int N_TX = 5;

	typedef struct packed {
		ctl_ep_t             ep0;
		dir_ep_t [N_TX-1:0]  tx;
		dir_ep_t             rx2;
		logic [6:0]          dev_addr;
		logic                forced_bus_reset;
		logic                bus_reset_s1;
		logic                bus_reset_s2;
		logic [7:0]          rdata;
		handshake_t          handshake;
		logic                tx_pid;
		logic                rx_expect;
	} state_t;

	state_t st;
	state_t next_st;
	logic   usb_rst;
	logic   hit;
	logic   ok_ep0;
	logic   ok_tx;
	logic   ok_rx2;
	logic [1:0] tx_stat_cur;
	logic [1:0] rx_stat_cur;

	// Bus reset pin crosses in from the transceiver, forced reset is ours
	assign usb_rst = st.bus_reset_s2 | st.forced_bus_reset;

	// Combinational next state
	always_comb begin
		next_st = st;
		next_st.bus_reset_s1 = i_bus_reset;
		next_st.bus_reset_s2 = st.bus_reset_s1;
		// address match gates every transaction-driven state update
		hit    = i_xact.done && (i_xact.dev_addr == st.dev_addr);
		ok_ep0 = hit && i_xact.ok && (i_xact.ep == 3'h0);
		ok_tx  = hit && i_xact.ok && (i_xact.ep != 3'h0) && (i_xact.ep <= 3'h5) && (i_xact.pid == `PID_IN);
		ok_rx2 = hit && i_xact.ok && (i_xact.ep == 3'h2) && (i_xact.pid == `PID_OUT);

		// Register writes first, so that hardware events below win
		if (i_req.wr) begin
			case (i_req.addr)
				`EP_OFS_CONTROL: begin
					next_st.ep0.txtog  = i_req.wdata[`CTL_TXTOG_BIT];
					next_st.ep0.txstat = i_req.wdata[`CTL_TXSTAT_HI:`CTL_TXSTAT_LO];
					next_st.ep0.rxtog  = i_req.wdata[`CTL_RXTOG_BIT];
					next_st.ep0.rxstat = i_req.wdata[1:0];
					if (!i_req.wdata[`CTL_DONE_BIT]) begin
						next_st.ep0.done = 1'b0;
					end
				end
				`EP_OFS_RX2: begin
					next_st.rx2.tog  = i_req.wdata[`EP_TOG_BIT];
					next_st.rx2.stat = i_req.wdata[1:0];
					if (!i_req.wdata[`EP_DONE_BIT]) begin
						next_st.rx2.done = 1'b0;
					end
				end
				`EP_OFS_ADDR: begin
					next_st.dev_addr = i_req.wdata[6:0];
				end
				`EP_OFS_BUSCTL: begin
					next_st.forced_bus_reset = i_req.wdata[0];
				end
				default: begin
					for (int i = 0; i < N_TX; i++) begin
						if (i_req.addr == ((i == 0) ? `EP_OFS_TX1 : (i == 1) ? `EP_OFS_TX2 :
							(i == 2) ? `EP_OFS_TX3 : (i == 3) ? `EP_OFS_TX4 : `EP_OFS_TX5)) begin
							next_st.tx[i].tog  = i_req.wdata[`EP_TOG_BIT];
							next_st.tx[i].stat = i_req.wdata[1:0];
							if (!i_req.wdata[`EP_DONE_BIT]) begin
								next_st.tx[i].done = 1'b0;
							end
						end
					end
				end
			endcase
		end

		// Endpoint 0 hardware updates
		if (hit && (i_xact.ep == 3'h0)) begin
			if (i_xact.stalled) begin
				next_st.ep0.txstat = `STAT_STALL;
				next_st.ep0.rxstat = `STAT_STALL;
			end else if (i_xact.pid == `PID_SETUP && st.ep0.rxstat != `STAT_DISABLED && i_xact.ok) begin
				// setup forces tx toggle to data1
				next_st.ep0.txtog  = 1'b1;
				next_st.ep0.rxtog  = 1'b0;
				next_st.ep0.txstat = `STAT_NAK;
				next_st.ep0.rxstat = `STAT_NAK;
				next_st.ep0.done   = 1'b1;
			end else if (ok_ep0) begin
				next_st.ep0.done   = 1'b1;
				next_st.ep0.txstat = `STAT_NAK;
				next_st.ep0.rxstat = `STAT_NAK;
				// tx toggle flips only on host ack
				if (i_xact.pid == `PID_IN && i_xact.host_ack) begin
					next_st.ep0.txtog = ~st.ep0.txtog;
				end
				// rx toggle flips on matching data pid
				if (i_xact.pid == `PID_OUT && i_xact.data_pid == st.ep0.rxtog) begin
					next_st.ep0.rxtog = ~st.ep0.rxtog;
				end
			end
		end

		// Transmit endpoints 1 to 5
		for (int i = 0; i < N_TX; i++) begin
			if (ok_tx && (i_xact.ep == 3'(i + 1))) begin
				next_st.tx[i].done = 1'b1;
				next_st.tx[i].stat = `STAT_NAK;
				if (i_xact.host_ack) begin
					next_st.tx[i].tog = ~st.tx[i].tog;
				end
			end
		end

		// Endpoint 2 reception
		if (ok_rx2) begin
			next_st.rx2.done = 1'b1;
			next_st.rx2.stat = `STAT_NAK;
			// toggle flips on matching data pid
			if (i_xact.data_pid == st.rx2.tog) begin
				next_st.rx2.tog = ~st.rx2.tog;
			end
		end

		// bus reset clears control fields 6:4 and 2:0
		// bus reset clears endpoint bits 2:0
		if (usb_rst) begin
			next_st.ep0.txtog  = 1'b0;
			next_st.ep0.txstat = `STAT_DISABLED;
			next_st.ep0.rxtog  = 1'b0;
			next_st.ep0.rxstat = `STAT_DISABLED;
			next_st.rx2.tog    = 1'b0;
			next_st.rx2.stat   = `STAT_DISABLED;
			next_st.dev_addr   = 7'h00;
			for (int i = 0; i < N_TX; i++) begin
				next_st.tx[i].tog  = 1'b0;
				next_st.tx[i].stat = `STAT_DISABLED;
			end
		end

		// Handshake decision for the token now on the wire
		tx_stat_cur = `STAT_DISABLED;
		rx_stat_cur = `STAT_DISABLED;
		next_st.tx_pid    = 1'b0;
		next_st.rx_expect = 1'b0;
		if (i_tok_ep == 3'h0) begin
			tx_stat_cur = st.ep0.txstat;
			rx_stat_cur = st.ep0.rxstat;
			next_st.tx_pid    = st.ep0.txtog;
			next_st.rx_expect = st.ep0.rxtog;
		end else if (i_tok_ep == 3'h2) begin
			rx_stat_cur = st.rx2.stat;
			next_st.rx_expect = st.rx2.tog;
		end
		for (int i = 0; i < N_TX; i++) begin
			if (i_tok_ep == 3'(i + 1)) begin
				tx_stat_cur    = st.tx[i].stat;
				next_st.tx_pid = st.tx[i].tog;
			end
		end
		// rx encoding decides OUT and SETUP
		if (i_tok_addr != st.dev_addr || usb_rst) begin
			next_st.handshake = HS_IGNORE;
		end else if (i_tok_pid == `PID_SETUP) begin
			next_st.handshake = (i_tok_ep == 3'h0 && rx_stat_cur != `STAT_DISABLED) ? HS_HANDLE : HS_IGNORE;
		end else begin
			case ((i_tok_pid == `PID_IN) ? tx_stat_cur : rx_stat_cur)
				`STAT_STALL: next_st.handshake = HS_STALL;
				`STAT_NAK:   next_st.handshake = HS_NAK;
				`STAT_VALID: next_st.handshake = HS_HANDLE;
				default:     next_st.handshake = HS_IGNORE;
			endcase
		end

		// reserved bits read back as zero
		next_st.rdata = 8'h00;
		if (i_req.rd) begin
			case (i_req.addr)
				`EP_OFS_CONTROL: next_st.rdata = {st.ep0.done, st.ep0.txtog, st.ep0.txstat, 1'b0,
					st.ep0.rxtog, st.ep0.rxstat};
				`EP_OFS_RX2:     next_st.rdata = {4'h0, st.rx2};
				`EP_OFS_ADDR:    next_st.rdata = {1'b0, st.dev_addr};
				`EP_OFS_BUSCTL:  next_st.rdata = {7'h00, st.forced_bus_reset};
				`EP_OFS_TX1:     next_st.rdata = {4'h0, st.tx[0]};
				`EP_OFS_TX2:     next_st.rdata = {4'h0, st.tx[1]};
				`EP_OFS_TX3:     next_st.rdata = {4'h0, st.tx[2]};
				`EP_OFS_TX4:     next_st.rdata = {4'h0, st.tx[3]};
				`EP_OFS_TX5:     next_st.rdata = {4'h0, st.tx[4]};
				default:         next_st.rdata = 8'h00;
			endcase
		end
	end

	// State register; reset constants only
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata     = st.rdata;
	assign o_handshake = st.handshake;
	assign o_tx_pid    = st.tx_pid;
	assign o_rx_expect = st.rx_expect;

	// Assertions
	// A correct endpoint 0 outcome that neither stalls nor falls under bus reset
	sequence s_ep0_good;
		hit && i_xact.ok && i_xact.ep == 3'h0 && !i_xact.stalled && !usb_rst;
	endsequence

	// Its setup case, taken only while reception is not disabled
	sequence s_setup_taken;
		s_ep0_good ##0 (i_xact.pid == `PID_SETUP && st.ep0.rxstat != `STAT_DISABLED);
	endsequence

	// A token for our address that no bus reset hides
	sequence s_tok_ours;
		!usb_rst && i_tok_addr == st.dev_addr;
	endsequence

	chk_ep0_done_set: assert property (@(posedge i_clk) disable iff (i_rst)
		s_ep0_good |=> st.ep0.done) else $error("control done flag not set");
	chk_ep0_nak_both: assert property (@(posedge i_clk) disable iff (i_rst)
		s_ep0_good |=> st.ep0.txstat == `STAT_NAK && st.ep0.rxstat == `STAT_NAK) else $error("ep0 not nak");
	chk_stall_both: assert property (@(posedge i_clk) disable iff (i_rst)
		hit && i_xact.ep == 3'h0 && i_xact.stalled && !usb_rst |=> st.ep0.txstat == `STAT_STALL
		&& st.ep0.rxstat == `STAT_STALL) else $error("ep0 not stalled");

	chk_setup_txtog: assert property (@(posedge i_clk) disable iff (i_rst)
		s_setup_taken |=> st.ep0.txtog) else $error("setup left transmit toggle low");
	chk_setup_rxtog: assert property (@(posedge i_clk) disable iff (i_rst)
		s_setup_taken |=> !st.ep0.rxtog) else $error("setup left receive toggle high");
	chk_setup_nak: assert property (@(posedge i_clk) disable iff (i_rst)
		s_setup_taken |=> st.ep0.txstat == `STAT_NAK && st.ep0.rxstat == `STAT_NAK) else $error("setup not nak");

	chk_reset_clears: assert property (@(posedge i_clk) disable iff (i_rst)
		usb_rst |=> st.ep0.txtog == 1'b0 && st.ep0.rxstat == 2'h0 && st.tx[0].stat == 2'h0) else $error("reset");
	chk_ep_reset_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		usb_rst |=> st.rx2.tog == 1'b0 && st.rx2.stat == `STAT_DISABLED && st.tx[N_TX-1].tog == 1'b0
		&& st.tx[N_TX-1].stat == `STAT_DISABLED) else $error("endpoint fields survived bus reset");
	chk_addr_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
		usb_rst |=> st.dev_addr == 7'h00) else $error("device address survived bus reset");

	chk_tx_toggle_ack: assert property (@(posedge i_clk) disable iff (i_rst)
		!usb_rst && !i_req.wr && !(ok_tx && i_xact.host_ack && i_xact.ep == 3'h1) |=> $stable(st.tx[0].tog))
		else $error("tx toggle moved without ack");
	chk_tx_toggle_flip: assert property (@(posedge i_clk) disable iff (i_rst)
		ok_tx && i_xact.host_ack && i_xact.ep == 3'h1 && !usb_rst |=> st.tx[0].tog != $past(st.tx[0].tog))
		else $error("acked data left tx toggle");
	chk_ep0_tx_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!usb_rst && !(i_req.wr && i_req.addr == `EP_OFS_CONTROL) && !(hit && i_xact.ep == 3'h0)
		|=> $stable(st.ep0.txtog)) else $error("control tx toggle moved on its own");

	chk_rx2_tog_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!usb_rst && !(i_req.wr && i_req.addr == `EP_OFS_RX2) && !(ok_rx2 && i_xact.data_pid == st.rx2.tog)
		|=> $stable(st.rx2.tog)) else $error("rx toggle moved on its own");
	chk_rx2_tog_flip: assert property (@(posedge i_clk) disable iff (i_rst)
		ok_rx2 && i_xact.data_pid == st.rx2.tog && !usb_rst |=> st.rx2.tog != $past(st.rx2.tog))
		else $error("matching data left rx toggle");

	chk_tx_done_set: assert property (@(posedge i_clk) disable iff (i_rst)
		ok_tx && i_xact.ep == 3'h1 && !usb_rst |=> st.tx[0].done && st.tx[0].stat == `STAT_NAK) else $error("tx done");
	chk_rx2_done_set: assert property (@(posedge i_clk) disable iff (i_rst)
		ok_rx2 && !usb_rst |=> st.rx2.done && st.rx2.stat == `STAT_NAK) else $error("rx2 done");
	chk_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
		ok_rx2 && i_req.wr && i_req.addr == `EP_OFS_RX2 |=> st.rx2.done) else $error("clear beat set");

	chk_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.rd && i_req.addr == `EP_OFS_TX3 |=> o_rdata[7:4] == 4'h0) else $error("reserved bits set");
	chk_reserved_ctl: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req.rd && i_req.addr == `EP_OFS_CONTROL |=> o_rdata[3] == 1'b0) else $error("control bit 3 set");
	chk_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_req.rd |=> o_rdata == 8'h00) else $error("read data without a read");

	chk_addr_gate: assert property (@(posedge i_clk) disable iff (i_rst)
		i_tok_addr != st.dev_addr |=> o_handshake == HS_IGNORE) else $error("foreign address answered");
	chk_tx_stall_hs: assert property (@(posedge i_clk) disable iff (i_rst)
		s_tok_ours ##0 (i_tok_pid == `PID_IN && i_tok_ep == 3'h4 && st.tx[3].stat == `STAT_STALL)
		|=> o_handshake == HS_STALL) else $error("stalled endpoint did not stall");
	chk_tx_valid_hs: assert property (@(posedge i_clk) disable iff (i_rst)
		s_tok_ours ##0 (i_tok_pid == `PID_IN && i_tok_ep == 3'h4 && st.tx[3].stat == `STAT_VALID)
		|=> o_handshake == HS_HANDLE) else $error("valid endpoint not handled");
	chk_ep0_in_nak: assert property (@(posedge i_clk) disable iff (i_rst)
		s_tok_ours ##0 (i_tok_pid == `PID_IN && i_tok_ep == 3'h0 && st.ep0.txstat == `STAT_NAK)
		|=> o_handshake == HS_NAK) else $error("control IN not naked");
	chk_ep0_out_off: assert property (@(posedge i_clk) disable iff (i_rst)
		s_tok_ours ##0 (i_tok_pid == `PID_OUT && i_tok_ep == 3'h0 && st.ep0.rxstat == `STAT_DISABLED)
		|=> o_handshake == HS_IGNORE) else $error("disabled reception answered");
	chk_setup_hs: assert property (@(posedge i_clk) disable iff (i_rst)
		s_tok_ours ##0 (i_tok_pid == `PID_SETUP && i_tok_ep == 3'h0 && st.ep0.rxstat != `STAT_DISABLED)
		|=> o_handshake == HS_HANDLE) else $error("setup token not handled");
endmodule

// file: core/usb_ep_ctl_params.svh
// Register offsets, field positions, reset values and encodings of the endpoint control block
`ifndef USB_EP_CTL_PARAMS_SVH
`define USB_EP_CTL_PARAMS_SVH
`define EP_OFS_CONTROL   8'h25
`define EP_OFS_TX1       8'h28
`define EP_OFS_RX2       8'h2a
`define EP_OFS_TX2       8'h2c
`define EP_OFS_TX3       8'h2e
`define EP_OFS_TX4       8'h30
`define EP_OFS_TX5       8'h32
`define EP_OFS_ADDR      8'h23
`define EP_OFS_BUSCTL    8'h22
`define EP_RESET_VALUE   8'h00
`define CTL_DONE_BIT     7
`define CTL_TXTOG_BIT    6
`define CTL_TXSTAT_HI    5
`define CTL_TXSTAT_LO    4
`define CTL_RXTOG_BIT    2
`define EP_DONE_BIT      3
`define EP_TOG_BIT       2
`define STAT_DISABLED    2'h0
`define STAT_STALL       2'h1
`define STAT_NAK         2'h2
`define STAT_VALID       2'h3
`define PID_OUT          2'h0
`define PID_IN           2'h2
`define PID_SETUP        2'h3
`endif

// file: core/usb_ep_ctl_pkg.sv
// Types shared by the endpoint control block
package usb_ep_ctl_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;
	// One transaction outcome reported by the packet engine
	typedef struct packed {
		logic       done;     // Transaction finished this cycle
		logic       ok;       // Completed without error
		logic [1:0] pid;      // Token kind: out, in, setup
		logic [2:0] ep;       // Endpoint number
		logic [6:0] dev_addr; // Address carried by the token
		logic       host_ack; // Host acked our data packet
		logic       data_pid; // Received data PID (0 data0, 1 data1)
		logic       stalled;  // Device answered with stall
	} xact_t;
	// Handshake decision offered for the current token
	typedef enum logic [1:0] {
		HS_IGNORE,
		HS_STALL,
		HS_NAK,
		HS_HANDLE
	} handshake_t;
	typedef struct packed {
		logic       done;
		logic       txtog;
		logic [1:0] txstat;
		logic       rxtog;
		logic [1:0] rxstat;
	} ctl_ep_t;
	typedef struct packed {
		logic       done;
		logic       tog;
		logic [1:0] stat;
	} dir_ep_t;
endpackage

// file: dv/usb_ep_ctl_tb.sv
// Self-checking bench of the endpoint control block
`timescale 1ns/100ps
`include "usb_ep_ctl_params.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module usb_ep_ctl_tb;
	import usb_ep_ctl_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        bus_rst = 1'b0;
	reg_req_t    req = '0;
	logic [7:0]  rdata;
	xact_t       xa;
	logic [1:0]  tpid;
	logic [2:0]  tep;
	logic [6:0]  tad;
	handshake_t  hs;
	logic        tx_pid;
	logic        rx_exp;
	int          mismatches = 0;
	int          checked = 0;
	// Address, write data, expected readback
	logic [23:0] rows [9] = '{24'h25ff77, 24'h28ff07, 24'h2c0505, 24'h2e0606, 24'h300303,
		24'h32ff07, 24'h2aff07, 24'h40ff00, 24'h238505};
	always #2.5 i_clk = ~i_clk;
	usb_ep_ctl u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata), .i_bus_reset(bus_rst),
		.i_xact(xa), .i_tok_pid(tpid), .i_tok_ep(tep), .i_tok_addr(tad), .o_handshake(hs),
		.o_tx_pid(tx_pid), .o_rx_expect(rx_exp));
	usb_host_model u_host (.i_clk(i_clk), .o_xact(xa), .o_tok_pid(tpid), .o_tok_ep(tep), .o_tok_addr(tad));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk);
		req.wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge i_clk);
		req.rd <= 1'b0;
		@(negedge i_clk);
		`CHK("rdata", e, rdata)
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog in case the sequence stalls
	initial begin
		#100000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		// Reset values of every endpoint register
		foreach (rows[i]) rd(rows[i][23:16], `EP_RESET_VALUE);
		// Reserved bits, write-one on flags, unmapped place
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		// Setup on a valid control endpoint, handled at the token
		wr(`EP_OFS_CONTROL, 8'h33);
		u_host.token(`PID_SETUP, 3'h0, 7'h05);
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		`CHK("handshake", HS_HANDLE, hs)
		u_host.xact(`PID_SETUP, 3'h0, 7'h05, 1'b0, 1'b0, 1'b1, 1'b0);
		rd(`EP_OFS_CONTROL, 8'he2);
		// Transmit now naked and armed with data1
		u_host.token(`PID_IN, 3'h0, 7'h05);
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		`CHK("handshake", HS_NAK, hs)
		`CHK("tx_pid", 1'b1, tx_pid)
		// Software clears the flag and rewrites both toggles
		wr(`EP_OFS_CONTROL, 8'h22);
		rd(`EP_OFS_CONTROL, 8'h22);
		// Stall answer puts both directions in stall
		wr(`EP_OFS_CONTROL, 8'h33);
		u_host.xact(`PID_OUT, 3'h0, 7'h05, 1'b0, 1'b0, 1'b0, 1'b1);
		rd(`EP_OFS_CONTROL, 8'h11);
		// Acked IN on endpoint 1
		wr(`EP_OFS_TX1, 8'h03);
		u_host.xact(`PID_IN, 3'h1, 7'h05, 1'b1, 1'b0, 1'b1, 1'b0);
		rd(`EP_OFS_TX1, 8'h0e);
		// Good OUT with matching data PID on endpoint 2
		wr(`EP_OFS_RX2, 8'h03);
		u_host.xact(`PID_OUT, 3'h2, 7'h05, 1'b0, 1'b0, 1'b1, 1'b0);
		rd(`EP_OFS_RX2, 8'h0e);
		u_host.token(`PID_OUT, 3'h2, 7'h05);
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		`CHK("handshake", HS_NAK, hs)
		`CHK("rx_expect", 1'b1, rx_exp)
		// Software clear and good OUT in one cycle: the set wins
		fork
			wr(`EP_OFS_RX2, 8'h03);
			u_host.xact(`PID_OUT, 3'h2, 7'h05, 1'b0, 1'b1, 1'b1, 1'b0);
		join
		rd(`EP_OFS_RX2, 8'h0a);
		// Foreign device address leaves the endpoint alone
		wr(`EP_OFS_TX3, 8'h03);
		u_host.xact(`PID_IN, 3'h3, 7'h09, 1'b1, 1'b0, 1'b1, 1'b0);
		rd(`EP_OFS_TX3, 8'h03);
		// Every status code answers the token accordingly
		for (int s = 0; s < 4; s++) begin
			wr(`EP_OFS_TX4, 8'(s) | 8'h04);
			u_host.token(`PID_IN, 3'h4, 7'h05);
			repeat (2) @(posedge i_clk);
			@(negedge i_clk);
			`CHK("handshake", handshake_t'(s[1:0]), hs)
			`CHK("tx_pid", 1'b1, tx_pid)
		end
		// Bus reset from the line keeps done flags only
		@(posedge i_clk);
		bus_rst <= 1'b1;
		repeat (4) @(posedge i_clk);
		bus_rst <= 1'b0;
		repeat (4) @(posedge i_clk);
		rd(`EP_OFS_TX1, 8'h08);
		rd(`EP_OFS_CONTROL, 8'h00);
		rd(`EP_OFS_ADDR, 8'h00);
		// Disabled reception after bus reset ignores a matching token
		u_host.token(`PID_OUT, 3'h0, 7'h00);
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		`CHK("handshake", HS_IGNORE, hs)
		// Forced reset through the bus control register; done bit written one to keep it
		wr(`EP_OFS_RX2, 8'h0f);
		wr(`EP_OFS_BUSCTL, 8'h01);
		wr(`EP_OFS_BUSCTL, 8'h00);
		repeat (4) @(posedge i_clk);
		rd(`EP_OFS_RX2, 8'h08);
		// Chip reset in mid-run also drops the done flags
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		`CHK("handshake", HS_IGNORE, hs)
		rd(`EP_OFS_TX1, `EP_RESET_VALUE);
		rd(`EP_OFS_RX2, `EP_RESET_VALUE);
		tally_and_finish;
	end
endmodule

// file: dv/usb_host_model.sv
// Behavioural full-speed host: presents tokens and transaction outcomes
`timescale 1ns/100ps
module usb_host_model (
	input  wire logic              i_clk,
	output usb_ep_ctl_pkg::xact_t  o_xact,
	output logic [1:0]             o_tok_pid,
	output logic [2:0]             o_tok_ep,
	output logic [6:0]             o_tok_addr
);
	import usb_ep_ctl_pkg::*;
	// Quiet bus at time zero
	initial begin
		o_xact = '0;
		o_tok_pid = 2'h0;
		o_tok_ep = 3'h0;
		o_tok_addr = 7'h7f;
	end
	// One-cycle outcome, then inverted fields so stale values never look valid
	task automatic xact(input logic [1:0] pid, input logic [2:0] ep, input logic [6:0] da,
		input logic ack, input logic dpid, input logic ok, input logic stl);
		@(posedge i_clk);
		o_xact <= '{1'b1, ok, pid, ep, da, ack, dpid, stl};
		@(posedge i_clk);
		o_xact <= ~o_xact;
	endtask
	// Token level held until the next one
	task automatic token(input logic [1:0] pid, input logic [2:0] ep, input logic [6:0] da);
		@(posedge i_clk);
		o_tok_pid <= pid;
		o_tok_ep <= ep;
		o_tok_addr <= da;
	endtask
endmodule
